// file: hdl/multichip_sync_control.sv
// Operation
// - Register at address 0x03 holds the synchronization settings except slave polarity and differential clock enable, 32 bits wide.
// - Bits 31:27 set correlation threshold for accepting received sync pulses.
// - Bit 26 enables sync receive logic; cleared by default.
// - Bit 25 enables output sync pulse generator; cleared by default.
// - Bits 23:19 delay received pulse; ignored while driver enable cleared.
// - Bit 18 selects manual (0) or automatic continuous (1) error check.
// - Bit 16 enables slave mode; data clock pin becomes sampling clock input.
// - Bits 15:11 delay emitted pulse in sample clocks; ignored without driver enable.
// - Bit 9 selects launch edge: rising when clear, falling when set.
// - Bit 8 with output enable loops internal pulse to receiver, pins ignored.
// - Bits 7:4 give state loaded into clock generator on synchronization.
// - Bits 3:0 set receiver window margin; ignored without driver enable.
// - Slave mode samples on rising edge if polarity bit set, else falling.
// - Differential clock enable clear: sync pads carry sync logic, not data clock.
`timescale 1ns/1ps
module multichip_sync_control
   import multichip_sync_pkg::*;
#(
   parameter int SYNC_PERIOD = SYNC_PERIOD_CYCLES,
   parameter int PULSE_LEN   = PULSE_CYCLES
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_b,
   input  wire logic [REG_ADDR_W-1:0] i_reg_addr,
   input  wire logic                  i_reg_wr,
   input  wire logic [31:0]           i_reg_wdata,
   output logic [31:0]                o_reg_rdata,
   input  wire logic                  i_data_sync_rising,
   input  wire logic                  i_diff_data_port_clock_out_en,
   input  wire logic                  i_data_port_clock_int,
   input  wire logic                  i_error_check_req,
   input  wire logic                  i_sync_in,
   input  wire logic                  i_slave_sampling_clock_in,
   output logic                       o_sync_out_pad,
   output logic                       o_sync_out_fall,
   output logic                       o_data_port_clock_out,
   output logic                       o_data_port_clock_oe_b,
   output logic                       o_sample_strobe,
   output logic                       o_sync_locked,
   output logic                       o_sync_error,
   output logic                       o_check_busy,
   output logic                       o_clk_state_load,
   output logic [3:0]                 o_clk_gen_state
);

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   logic [31:0] multichip_alignment_config;
   logic        cfg_hit;

   assign cfg_hit = (i_reg_addr == MULTICHIP_ALIGNMENT_CONFIG_ADDR);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         multichip_alignment_config <= MULTICHIP_ALIGNMENT_CONFIG_RESET;
         o_reg_rdata                <= 32'h0000_0000;
      end else begin
         if (i_reg_wr && cfg_hit) begin
            multichip_alignment_config <= i_reg_wdata;
         end
         o_reg_rdata <= cfg_hit ? multichip_alignment_config : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   wire logic [4:0] corr_thresh = multichip_alignment_config[CORR_THRESH_MSB:CORR_THRESH_LSB];
   wire logic       rx_en       = multichip_alignment_config[SYNC_RX_EN_BIT];
   wire logic       tx_en       = multichip_alignment_config[SYNC_TX_EN_BIT];
   wire logic [4:0] in_delay_w  = multichip_alignment_config[IN_DELAY_MSB:IN_DELAY_LSB];
   wire logic       err_auto    = multichip_alignment_config[ERR_AUTO_BIT];
   wire logic       slave_mode  = multichip_alignment_config[SLAVE_MODE_BIT];
   wire logic [4:0] out_delay_w = multichip_alignment_config[OUT_DELAY_MSB:OUT_DELAY_LSB];
   wire logic       out_fall    = multichip_alignment_config[OUT_FALL_BIT];
   wire logic       loopback    = multichip_alignment_config[LOOPBACK_BIT];
   wire logic [3:0] clk_state   = multichip_alignment_config[CLK_STATE_MSB:CLK_STATE_LSB];
   wire logic [3:0] window_w    = multichip_alignment_config[WINDOW_MSB:WINDOW_LSB];

   // Delay words only count while the driver is enabled
   wire logic [4:0] in_delay  = tx_en ? in_delay_w : 5'h00;
   wire logic [4:0] out_delay = tx_en ? out_delay_w : 5'h00;
   wire logic [3:0] margin    = tx_en ? window_w : 4'h0;
   wire logic       use_loop  = loopback && tx_en;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] sync_in_ff;
   logic [1:0] dci_ff;
   logic       dci_prev;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_in_ff <= 2'b00;
         dci_ff     <= 2'b00;
         dci_prev   <= 1'b0;
      end else begin
         sync_in_ff <= {sync_in_ff[0], i_sync_in};
         dci_ff     <= {dci_ff[0], i_slave_sampling_clock_in};
         dci_prev   <= dci_ff[1];
      end
   end

   // ----------------------------------------
   // Slave mode data clock
   // ----------------------------------------
   wire logic dci_rise = dci_ff[1] && !dci_prev;
   wire logic dci_fall = !dci_ff[1] && dci_prev;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sample_strobe        <= 1'b0;
         o_data_port_clock_oe_b <= 1'b0;
         o_data_port_clock_out  <= 1'b0;
      end else begin
         o_sample_strobe        <= slave_mode && (i_data_sync_rising ? dci_rise : dci_fall);
         o_data_port_clock_oe_b <= slave_mode;
         o_data_port_clock_out  <= slave_mode ? 1'b0 : i_data_port_clock_int;
      end
   end

   // ----------------------------------------
   // Pulse generator
   // ----------------------------------------
   logic [15:0]           period_cnt;
   logic [7:0]            pulse_cnt;
   logic                  pulse_raw;
   logic [DELAY_TAPS-1:0] out_line;
   logic                  tx_pulse;

   wire logic period_end = (period_cnt == 16'(SYNC_PERIOD - 1));
   wire logic tx_tap     = (out_delay == 5'h00) ? pulse_raw : out_line[out_delay - 5'h01];

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         period_cnt <= 16'h0000;
         pulse_cnt  <= 8'h00;
         pulse_raw  <= 1'b0;
      end else if (!tx_en) begin
         period_cnt <= 16'h0000;
         pulse_cnt  <= 8'h00;
         pulse_raw  <= 1'b0;
      end else begin
         period_cnt <= period_end ? 16'h0000 : period_cnt + 16'h0001;
         if (period_end) begin
            pulse_cnt <= 8'(PULSE_LEN);
            pulse_raw <= 1'b1;
         end else if (pulse_cnt != 8'h00) begin
            pulse_cnt <= pulse_cnt - 8'h01;
            pulse_raw <= (pulse_cnt != 8'h01);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_line <= '0;
         tx_pulse <= 1'b0;
      end else begin
         out_line <= tx_en ? {out_line[DELAY_TAPS-2:0], pulse_raw} : '0;
         tx_pulse <= tx_en && tx_tap;
      end
   end

   // ----------------------------------------
   // Output pads
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sync_out_pad  <= 1'b0;
         o_sync_out_fall <= 1'b0;
      end else begin
         o_sync_out_pad  <= i_diff_data_port_clock_out_en ? i_data_port_clock_int
                                              : (tx_en && tx_pulse);
         o_sync_out_fall <= out_fall;
      end
   end

   // ----------------------------------------
   // Receive path
   // ----------------------------------------
   logic [DELAY_TAPS-1:0] in_line;
   logic                  rx_sample;
   logic                  rx_match;

   wire logic rx_source = use_loop ? tx_pulse : sync_in_ff[1];

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         in_line   <= '0;
         rx_sample <= 1'b0;
      end else begin
         in_line   <= rx_en ? {in_line[DELAY_TAPS-2:0], rx_source} : '0;
         rx_sample <= rx_en && (in_delay == 5'h00 ? rx_source : in_line[in_delay - 5'h01]);
      end
   end

   sync_correlator #(
      .LEN     (CORR_LEN),
      .PATTERN (SYNC_PATTERN)
   ) u_corr (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_enable    (rx_en),
      .i_sample    (rx_sample),
      .i_threshold (corr_thresh),
      .o_match     (rx_match),
      .o_score     ()
   );

   // ----------------------------------------
   // Clock generation state load
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_clk_gen_state  <= 4'h0;
         o_clk_state_load <= 1'b0;
         o_sync_locked    <= 1'b0;
      end else begin
         o_clk_state_load <= rx_match;
         if (rx_match) begin
            o_clk_gen_state <= clk_state;
         end else begin
            o_clk_gen_state <= o_clk_gen_state + 4'h1;
         end
         if (!rx_en) begin
            o_sync_locked <= 1'b0;
         end else if (rx_match) begin
            o_sync_locked <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Pulse spacing error check
   // ----------------------------------------
   check_state_t chk_state;
   check_state_t next_chk_state;
   logic [16:0]  since_cnt;
   logic         chk_pend;

   wire logic [16:0] early_lim = 17'(SYNC_PERIOD) - {13'h0000, margin};
   wire logic [16:0] late_lim  = 17'(SYNC_PERIOD) + {13'h0000, margin};
   wire logic        in_win    = (since_cnt >= early_lim) && (since_cnt <= late_lim);
   wire logic        overdue   = (since_cnt > late_lim);
   wire logic        armed     = (chk_state == CHK_ARMED);
   wire logic        bad_event = armed && ((rx_match && !in_win) || overdue);

   always_comb begin
      next_chk_state = chk_state;
      unique case (chk_state)
         CHK_IDLE: begin
            if ((err_auto || chk_pend || i_error_check_req) && rx_match) begin
               next_chk_state = CHK_ARMED;
            end
         end
         CHK_ARMED: begin
            if (rx_match || overdue) begin
               next_chk_state = err_auto ? CHK_ARMED : CHK_DONE;
            end
         end
         CHK_DONE: begin
            if (err_auto || i_error_check_req) begin
               next_chk_state = CHK_IDLE;
            end
         end
      endcase
      if (!rx_en) begin
         next_chk_state = CHK_IDLE;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         chk_state    <= CHK_IDLE;
         since_cnt    <= 17'h00000;
         chk_pend     <= 1'b0;
         o_sync_error <= 1'b0;
      end else begin
         chk_state <= next_chk_state;
         // Manual request waits here for the next accepted pulse
         if (i_error_check_req) begin
            chk_pend <= 1'b1;
         end else if (!rx_en || chk_state == CHK_ARMED) begin
            chk_pend <= 1'b0;
         end
         if (rx_match || overdue || !rx_en) begin
            since_cnt <= 17'h00001;
         end else begin
            since_cnt <= since_cnt + 17'h00001;
         end
         if (bad_event) begin
            o_sync_error <= 1'b1;
         end else if (i_error_check_req || !rx_en) begin
            o_sync_error <= 1'b0;
         end
      end
   end

   assign o_check_busy = (chk_state != CHK_DONE) && (err_auto || chk_state == CHK_ARMED);

endmodule

// file: hdl/multichip_sync_pkg.sv
package multichip_sync_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int          REG_ADDR_W         = 5;
   localparam logic [4:0]  MULTICHIP_ALIGNMENT_CONFIG_ADDR = 5'h03;
   localparam logic [31:0] MULTICHIP_ALIGNMENT_CONFIG_RESET = 32'h0000_0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CORR_THRESH_LSB  = 27;
   localparam int CORR_THRESH_MSB  = 31;
   localparam int SYNC_RX_EN_BIT   = 26;
   localparam int SYNC_TX_EN_BIT   = 25;
   localparam int FIXED_LOW_HI_BIT = 24;
   localparam int IN_DELAY_LSB     = 19;
   localparam int IN_DELAY_MSB     = 23;
   localparam int ERR_AUTO_BIT     = 18;
   localparam int FIXED_LOW_LO_BIT = 17;
   localparam int SLAVE_MODE_BIT   = 16;
   localparam int OUT_DELAY_LSB    = 11;
   localparam int OUT_DELAY_MSB    = 15;
   localparam int FIXED_HIGH_BIT   = 10;
   localparam int OUT_FALL_BIT     = 9;
   localparam int LOOPBACK_BIT     = 8;
   localparam int CLK_STATE_LSB    = 4;
   localparam int CLK_STATE_MSB    = 7;
   localparam int WINDOW_LSB       = 0;
   localparam int WINDOW_MSB       = 3;

   // ----------------------------------------
   // Pulse format and timing
   // ----------------------------------------
   localparam int          DELAY_TAPS   = 32;
   localparam int          CORR_LEN     = 32;
   localparam logic [31:0] SYNC_PATTERN = 32'hffff_0000;
   localparam int          PULSE_CYCLES = 16;
   localparam int          SYNC_PERIOD_CYCLES = 1024;
   localparam int          CLK_PERIOD_PS = 5000;
   localparam int          SYNC_PERIOD_NS = 5120;
   localparam int          SYNC_PERIOD_FROM_NS = (SYNC_PERIOD_NS * 1000) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      CHK_IDLE,
      CHK_ARMED,
      CHK_DONE
   } check_state_t;

endpackage

// file: hdl/sync_correlator.sv
`timescale 1ns/1ps
module sync_correlator
   import multichip_sync_pkg::*;
#(
   parameter int          LEN     = CORR_LEN,
   parameter logic [31:0] PATTERN = SYNC_PATTERN
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_enable,
   input  wire logic       i_sample,
   input  wire logic [4:0] i_threshold,
   output logic            o_match,
   output logic [5:0]      o_score
);

   logic [LEN-1:0] window;
   logic [5:0]     score;
   logic           above;
   logic           above_q;

   // ----------------------------------------
   // Agreement count against the pulse shape
   // ----------------------------------------
   function automatic logic [5:0] agree(input logic [LEN-1:0] w, input logic [LEN-1:0] p);
      logic [5:0] n;
      n = 6'h00;
      for (int k = 0; k < LEN; k++) begin
         n = n + {5'h00, ~(w[k] ^ p[k])};
      end
      return n;
   endfunction

   assign score = agree(window, PATTERN[LEN-1:0]);
   assign above = i_enable && (score >= {1'b0, i_threshold});

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         window  <= '0;
         above_q <= 1'b0;
         o_match <= 1'b0;
         o_score <= 6'h00;
      end else begin
         window  <= i_enable ? {window[LEN-2:0], i_sample} : '0;
         above_q <= above;
         o_match <= above && !above_q;
         o_score <= score;
      end
   end

endmodule

// file: tb/peer_sync_model.sv
`timescale 1ns/1ps
module peer_sync_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_enable,
   input  wire logic [7:0] i_period,
   output logic            o_sync
);
   logic [7:0] cnt;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt <= 8'h00;
         o_sync <= 1'b0;
      end else if (!i_enable) begin
         cnt <= 8'h00;
         o_sync <= 1'b0;
      end else begin
         cnt <= (cnt == i_period - 8'h01) ? 8'h00 : cnt + 8'h01;
         o_sync <= (cnt < 8'h10);
      end
   end
endmodule

// file: tb/sync_ctrl_monitor.sv
`timescale 1ns/1ps
module sync_ctrl_monitor
   import multichip_sync_pkg::*;
#(
   parameter int SYNC_PERIOD = SYNC_PERIOD_CYCLES,
   parameter int PULSE_LEN   = PULSE_CYCLES
) (
   input wire logic                  i_clk,
   input wire logic                  i_rst_b,
   input wire logic [REG_ADDR_W-1:0] i_reg_addr,
   input wire logic                  i_reg_wr,
   input wire logic [31:0]           i_reg_wdata,
   input wire logic [31:0]           o_reg_rdata,
   input wire logic                  i_diff_data_port_clock_out_en,
   input wire logic                  i_data_port_clock_int,
   input wire logic                  o_sync_out_pad,
   input wire logic                  o_sync_out_fall,
   input wire logic                  o_data_port_clock_oe_b,
   input wire logic                  o_sync_locked,
   input wire logic                  o_clk_state_load,
   input wire logic [3:0]            o_clk_gen_state
);
   // ----------------------------------------
   // Config shadow and idle counter
   // ----------------------------------------
   logic [31:0] cfg;
   logic [5:0]  off_cnt;
   logic [5:0]  next_off;
   logic [7:0]  hi_run;
   wire         cfg_wr = i_reg_wr && (i_reg_addr == MULTICHIP_ALIGNMENT_CONFIG_ADDR);
   assign next_off = cfg[SYNC_TX_EN_BIT] ? 6'h00 : (off_cnt == 6'h3f ? off_cnt : off_cnt + 6'h01);
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg <= '0;
         off_cnt <= '0;
         hi_run <= '0;
      end else begin
         off_cnt <= next_off;
         hi_run <= o_sync_out_pad ? (hi_run == 8'hff ? hi_run : hi_run + 8'h01) : 8'h00;
         if (cfg_wr) begin
            cfg <= i_reg_wdata;
         end
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_load_once;
      o_sync_locked ##1 !o_clk_state_load;
   endsequence
   reg_readback_a: assert property (
      cfg_wr ##1 (i_reg_addr == MULTICHIP_ALIGNMENT_CONFIG_ADDR)
      |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("config readback wrong");
   unmapped_read_a: assert property (
      i_reg_addr != MULTICHIP_ALIGNMENT_CONFIG_ADDR |=> o_reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   tx_idle_a: assert property (
      off_cnt == 6'h3f && !i_diff_data_port_clock_out_en && !$past(i_diff_data_port_clock_out_en) |-> !o_sync_out_pad)
      else $error("pulse while generator off");
   burst_len_a: assert property (
      $fell(o_sync_out_pad) && cfg[SYNC_TX_EN_BIT] && !i_diff_data_port_clock_out_en
      && !$past(i_diff_data_port_clock_out_en) |-> hi_run == 8'(PULSE_LEN)) else $error("pulse width wrong");
   diff_copy_a: assert property (
      i_diff_data_port_clock_out_en && $past(i_diff_data_port_clock_out_en)
      |-> o_sync_out_pad == $past(i_data_port_clock_int)) else $error("pad not data clock");
   slave_pin_a: assert property (
      o_data_port_clock_oe_b == $past(cfg[SLAVE_MODE_BIT])) else $error("clock pin dir wrong");
   fall_copy_a: assert property (
      o_sync_out_fall == $past(cfg[OUT_FALL_BIT])) else $error("launch edge wrong");
   locked_clear_a: assert property (
      !cfg[SYNC_RX_EN_BIT] && !$past(cfg[SYNC_RX_EN_BIT]) |-> !o_sync_locked)
      else $error("locked while receiver off");
   load_state_a: assert property (
      o_clk_state_load |-> o_clk_gen_state == cfg[CLK_STATE_MSB:CLK_STATE_LSB])
      else $error("clock state not loaded");
   load_pulse_a: assert property (
      o_clk_state_load |-> s_load_once) else $error("load pulse wrong");
endmodule

bind multichip_sync_control sync_ctrl_monitor #(
   .SYNC_PERIOD(SYNC_PERIOD),
   .PULSE_LEN  (PULSE_LEN)
) u_mon (
   .i_clk, .i_rst_b, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata,
   .i_diff_data_port_clock_out_en, .i_data_port_clock_int, .o_sync_out_pad, .o_sync_out_fall,
   .o_data_port_clock_oe_b, .o_sync_locked, .o_clk_state_load, .o_clk_gen_state
);

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   import multichip_sync_pkg::*;
   logic        i_clk, i_rst_b, i_reg_wr, i_data_sync_rising, i_diff_data_port_clock_out_en;
   logic        i_data_port_clock_int, i_error_check_req, i_sync_in, i_slave_sampling_clock_in;
   logic [4:0]  i_reg_addr;
   logic [31:0] i_reg_wdata, o_reg_rdata, d;
   logic        o_sync_out_pad, o_sync_out_fall, o_data_port_clock_out, o_data_port_clock_oe_b;
   logic        o_sample_strobe, o_sync_locked, o_sync_error, o_check_busy, o_clk_state_load;
   logic [3:0]  o_clk_gen_state;
   logic        peer_en;
   logic [7:0]  peer_per;
   int          fails, check_count, cycles, n, t0, t5, l1;
   wire  [1:0]  watch = {o_clk_state_load, o_sync_out_pad};

   multichip_sync_control #(.SYNC_PERIOD(64)) u_dut (.*);
   peer_sync_model u_peer (.i_clk, .i_rst_b, .i_enable(peer_en), .i_period(peer_per),
                           .o_sync(i_sync_in));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_wdata = v;
      i_reg_wr = 1'b1;
      @(negedge i_clk);
      i_reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(negedge i_clk);
      i_reg_addr = a;
      @(negedge i_clk);
      v = o_reg_rdata;
   endtask
   task automatic wait_hi(input int sel, output int k);
      k = 0;
      while (watch[sel] !== 1'b1 && k < 400) begin
         @(negedge i_clk);
         k++;
      end
   endtask
   task automatic slave_edge(input logic v, output int k);
      k = 99;
      i_slave_sampling_clock_in = v;
      for (int j = 1; j <= 8; j++) begin
         @(negedge i_clk);
         if (o_sample_strobe === 1'b1 && k == 99) k = j;
      end
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 12000) begin
         fails++;
         close_out();
      end
   end

   initial begin
      {i_reg_wr, i_data_sync_rising, i_diff_data_port_clock_out_en, i_data_port_clock_int} = '0;
      {i_error_check_req, i_slave_sampling_clock_in, i_rst_b, peer_en} = '0;
      i_reg_addr = 5'h00;
      i_reg_wdata = 32'h0;
      peer_per = 8'h40;
      repeat (6) @(negedge i_clk);
      i_rst_b = 1'b1;
      // ----------------------------------------
      // Register access
      // ----------------------------------------
      rd(5'h03, d);
      check(d, 32'h0);
      wr(5'h03, 32'hf8f8_7c3f);
      rd(5'h03, d);
      check(d, 32'hf8f8_7c3f);
      wr(5'h07, 32'hffff_ffff);
      rd(5'h07, d);
      check(d, 32'h0);
      rd(5'h03, d);
      check(d, 32'hf8f8_7c3f);
      $display("test registers done");
      // ----------------------------------------
      // Pulse generator
      // ----------------------------------------
      wr(5'h03, 32'h0000_0400);
      wait_hi(0, n);
      check(n, 400);
      wr(5'h03, 32'h0200_0400);
      wait_hi(0, t0);
      n = 0;
      while (watch[0] === 1'b1 && n < 40) begin
         @(negedge i_clk);
         n++;
      end
      check(n, 16);
      wait_hi(0, n);
      check(n, 48);
      repeat (20) @(negedge i_clk);
      wr(5'h03, 32'h0000_0400);
      repeat (80) @(negedge i_clk);
      wr(5'h03, 32'h0200_2c00);
      wait_hi(0, t5);
      check(t5 - t0, 5);
      wr(5'h03, 32'h0200_2e00);
      @(negedge i_clk);
      check(o_sync_out_fall, 1'b1);
      repeat (20) @(negedge i_clk);
      $display("test generator done");
      // ----------------------------------------
      // Receive, loopback and error check
      // ----------------------------------------
      wr(5'h03, 32'hfe00_05a0);
      wait_hi(1, n);
      check(o_clk_gen_state, 4'ha);
      check(o_sync_locked, 1'b1);
      wr(5'h03, 32'hf800_05a0);
      repeat (2) @(negedge i_clk);
      check(o_sync_locked, 1'b0);
      peer_en = 1'b1;
      wr(5'h03, 32'hfc04_0430);
      wait_hi(1, n);
      check(o_clk_gen_state, 4'h3);
      check(o_sync_locked, 1'b1);
      repeat (200) @(negedge i_clk);
      check(o_sync_error, 1'b0);
      check(o_check_busy, 1'b1);
      peer_per = 8'h50;
      repeat (250) @(negedge i_clk);
      check(o_sync_error, 1'b1);
      peer_per = 8'h40;
      wr(5'h03, 32'hfc00_0430);
      repeat (200) @(negedge i_clk);
      wait_hi(1, n);
      repeat (8) @(negedge i_clk);
      i_error_check_req = 1'b1;
      @(negedge i_clk);
      i_error_check_req = 1'b0;
      wait_hi(1, n);
      check(o_check_busy, 1'b1);
      repeat (200) @(negedge i_clk);
      check(o_sync_error, 1'b0);
      check(o_check_busy, 1'b0);
      peer_en = 1'b0;
      $display("test receive done");
      // ----------------------------------------
      // Slave mode and pad source
      // ----------------------------------------
      wr(5'h03, 32'h0001_0400);
      i_data_sync_rising = 1'b1;
      repeat (2) @(negedge i_clk);
      check(o_data_port_clock_oe_b, 1'b1);
      check(o_data_port_clock_out, 1'b0);
      slave_edge(1'b1, l1);
      check(l1 < 9, 1'b1);
      slave_edge(1'b0, n);
      check(n, 99);
      i_data_sync_rising = 1'b0;
      slave_edge(1'b1, n);
      check(n, 99);
      slave_edge(1'b0, n);
      check(n, l1);
      $display("test slave done");
      wr(5'h03, 32'h0000_0400);
      i_diff_data_port_clock_out_en = 1'b1;
      i_data_port_clock_int = 1'b1;
      repeat (3) @(negedge i_clk);
      check(o_sync_out_pad, 1'b1);
      check(o_data_port_clock_out, 1'b1);
      i_data_port_clock_int = 1'b0;
      repeat (3) @(negedge i_clk);
      check(o_sync_out_pad, 1'b0);
      i_diff_data_port_clock_out_en = 1'b0;
      i_data_port_clock_int = 1'b1;
      repeat (3) @(negedge i_clk);
      check(o_sync_out_pad, 1'b0);
      $display("test pad source done");
      close_out();
   end
endmodule
